// ### logic/csoir_alu_flags.sv
/*
  Combinational flag generator: result and zero, nibble carry and carry.
  Assumes operands are stable in the cycle the core presents them.
*/
`timescale 1ns/1ps
module csoir_alu_flags
    import csoir_pkg::*;
(
    input wire csoir_alu_req_t req_i,
    output csoir_alu_res_t res_o
);

    // ------------------------------------------------------------------
    // Flag arithmetic
    // ------------------------------------------------------------------
    // Subtraction adds the two's complement, so carry means no borrow.
    always_comb begin
        logic [8:0] sum;
        logic [4:0] nib;
        logic [7:0] b_eff;
        logic cin;
        sum = 9'h0_00;
        nib = 5'h00;
        b_eff = req_i.b;
        cin = 1'b0;
        res_o = '0;
        if (req_i.op == CSOIR_OP_SUB) begin
            b_eff = ~req_i.b;
            cin = 1'b1;
        end
        sum = {1'b0, req_i.a} + {1'b0, b_eff} + {8'h00, cin};
        nib = {1'b0, req_i.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
        unique case (req_i.op)
            CSOIR_OP_ADD, CSOIR_OP_SUB: begin
                res_o.result = sum[7:0];
                res_o.carry = sum[8];
                res_o.nibble = nib[4];
                res_o.upd_carry = 1'b1;
                res_o.upd_zero = 1'b1;
            end
            CSOIR_OP_LOGIC: begin
                res_o.result = req_i.logic_res;
                res_o.upd_zero = 1'b1;
            end
            CSOIR_OP_ROT_L: begin
                res_o.result = {req_i.a[6:0], req_i.b[0]};
                res_o.carry = req_i.a[7];
            end
            CSOIR_OP_ROT_R: begin
                res_o.result = {req_i.b[0], req_i.a[7:1]};
                res_o.carry = req_i.a[0];
            end
            default: begin
                res_o.result = req_i.logic_res;
            end
        endcase
        res_o.zero = (res_o.result == 8'h00);
    end

endmodule

// ### logic/csoir_pkg.sv
/*
  Constants, field layouts and carrier types shared by the core status,
  option and interrupt-control register bank.
  Assumes a single 200 MHz core clock and an instruction core that issues
  register accesses and flag updates as one-cycle strobes.
*/
// Behaviour
// - Bits 6:5 pick the direct-addressing bank; each bank is 128 bytes.
// - Timeout flag reads 1 after power-up, kick or sleep; 0 on watchdog timeout.
// - Power-down flag is 1 at power-up or kick, 0 on sleep.
// - Zero flag follows whether the operation result equals zero.
// - Digit carry is carry out of bit 3; borrow sense on subtract.
// - Carry is carry out of bit 7; subtract adds two's complement.
// - Rotates load carry with the bit shifted out of the source.
// - Option bit 7 high disables the port B weak pull-ups.
// - Option bit 6 picks external interrupt edge: 1 rising, 0 falling.
// - Option bit 5 picks timer clock source; bit 4 picks counted edge.
// - Option bit 3 gives the shared prescaler to watchdog (1) or timer (0).
// - Prescale ratio field divides by powers of two, per assignment.
// - All option bits read and write, and reset to 1.
// - Interrupt control holds three enables, two more enables, three flags in order.
// - Comparator enable and flag live outside, gated by peripheral enable.
// - Flags set on their condition regardless of any enable.
// - Interrupt control bits 7..1 reset to 0; bit 0 unknown; all read/write. The code resets bit 0 to 0 as well.
// - Writes of status as destination do not touch zero, digit carry, carry; logic ops still write digit carry and carry, rotates zero and digit carry.
// - Timeout and power-down flags ignore instruction writes.
package csoir_pkg;

    // ------------------------------------------------------------------
    // Register addresses and layout
    // ------------------------------------------------------------------
    localparam logic [8:0] CSOIR_ADDR_FLAGS_BANK = 9'h0_03;
    localparam logic [8:0] CSOIR_ADDR_IRQ_CTRL = 9'h0_0b;
    localparam logic [8:0] CSOIR_ADDR_OPTION = 9'h0_81;
    localparam logic [8:0] CSOIR_BANK_SPAN = 9'h0_80;
    localparam logic [6:0] CSOIR_BANK_MASK = 7'h7f;

    localparam int CSOIR_BIT_BANK_HI = 6;
    localparam int CSOIR_BIT_BANK_LO = 5;
    localparam int CSOIR_BIT_WDT_N = 4;
    localparam int CSOIR_BIT_SLEEP_N = 3;
    localparam int CSOIR_BIT_ZERO = 2;
    localparam int CSOIR_BIT_NIBBLE = 1;
    localparam int CSOIR_BIT_CARRY = 0;

    localparam logic [7:0] CSOIR_OPTION_RESET = 8'hff;
    localparam logic [7:0] CSOIR_IRQ_RESET = 8'h00;
    localparam logic [1:0] CSOIR_BANK_RESET = 2'h0;
    localparam logic [3:0] CSOIR_NIBBLE_MAX = 4'hf;

    // ------------------------------------------------------------------
    // ALU operations and carriers
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CSOIR_OP_NONE,
        CSOIR_OP_ADD,
        CSOIR_OP_SUB,
        CSOIR_OP_LOGIC,
        CSOIR_OP_ROT_L,
        CSOIR_OP_ROT_R
    } csoir_op_t;

    typedef struct packed {
        csoir_op_t op;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] logic_res;
    } csoir_alu_req_t;

    typedef struct packed {
        logic [7:0] result;
        logic zero;
        logic nibble;
        logic carry;
        logic upd_zero;
        logic upd_carry;
    } csoir_alu_res_t;

    typedef struct packed {
        logic weak_pullup_off;
        logic ext_irq_edge_pol;
        logic tick_source_sel;
        logic tick_edge_sel;
        logic prescale_assign;
        logic [2:0] prescale_ratio;
    } csoir_option_t;

    typedef struct packed {
        logic global_irq_enable;
        logic periph_irq_enable;
        logic tick_ovf_irq_enable;
        logic ext_pin_irq_enable;
        logic port_change_irq_enable;
        logic tick_ovf_flag;
        logic ext_pin_flag;
        logic port_change_flag;
    } csoir_irq_t;

endpackage

// ### logic/csoir_prescale.sv
/*
  Decodes the prescale ratio into a divide count for timer or watchdog.
  Assumes the downstream counter treats the count as a terminal value.
*/
`timescale 1ns/1ps
module csoir_prescale
    import csoir_pkg::*;
(
    input wire csoir_option_t opt_i,
    output logic [8:0] tick_div_o,
    output logic [8:0] wdt_div_o
);

    // ------------------------------------------------------------------
    // Ratio decode
    // ------------------------------------------------------------------
    // Only one side holds the prescaler; the other runs 1:1.
    always_comb begin
        tick_div_o = 9'h0_01;
        wdt_div_o = 9'h0_01;
        if (opt_i.prescale_assign) begin
            wdt_div_o = 9'h0_01 << opt_i.prescale_ratio;
        end else begin
            tick_div_o = 9'h0_02 << opt_i.prescale_ratio;
        end
    end

endmodule

// ### logic/csoir_regs.sv
/*
  Core status, option and interrupt-control register bank.
  Assumes the instruction core presents one register access per cycle
  and drives the flag-update and event strobes as one-cycle pulses.
*/
`timescale 1ns/1ps
module csoir_regs
    import csoir_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic [8:0] addr_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire csoir_alu_req_t alu_i,
    input wire logic alu_dest_status_i,
    input wire logic kick_watchdog_instr_i,
    input wire logic sleep_instr_i,
    input wire logic wdt_timeout_i,
    input wire logic tick_ovf_evt_i,
    input wire logic ext_pin_evt_i,
    input wire logic port_change_evt_i,
    input wire logic periph_pending_i,
    output logic [7:0] rdata_o,
    output logic [7:0] alu_result_o,
    output logic [1:0] bank_sel_o,
    output logic weak_pullup_off_o,
    output logic ext_irq_edge_pol_o,
    output logic tick_source_sel_o,
    output logic tick_edge_sel_o,
    output logic [8:0] tick_div_o,
    output logic [8:0] wdt_div_o,
    output logic periph_irq_enable_o,
    output logic irq_req_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [1:0] bank_q, bank_d;
    logic wdt_n_q, wdt_n_d;
    logic sleep_n_q, sleep_n_d;
    logic zero_q, zero_d;
    logic nib_q, nib_d;
    logic carry_q, carry_d;
    csoir_option_t opt_q, opt_d;
    csoir_irq_t irq_q, irq_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] res_q;
    logic [8:0] tdiv_q, wdiv_q;
    logic irq_req_q, irq_req_d;
    csoir_alu_res_t alu_res;
    logic [8:0] tdiv, wdiv;
    logic hit_status, hit_irq, hit_opt;

    csoir_alu_flags u_alu (
        .req_i(alu_i),
        .res_o(alu_res)
    );

    csoir_prescale u_pre (
        .opt_i(opt_q),
        .tick_div_o(tdiv),
        .wdt_div_o(wdiv)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Status and interrupt control answer in all four banks.
    assign hit_status = (addr_i[6:0] == CSOIR_ADDR_FLAGS_BANK[6:0]);
    assign hit_irq = (addr_i[6:0] == CSOIR_ADDR_IRQ_CTRL[6:0]);
    assign hit_opt = (addr_i == CSOIR_ADDR_OPTION);

    // ------------------------------------------------------------------
    // Status register next state
    // ------------------------------------------------------------------
    always_comb begin
        bank_d = bank_q;
        wdt_n_d = wdt_n_q;
        sleep_n_d = sleep_n_q;
        zero_d = zero_q;
        nib_d = nib_q;
        carry_d = carry_q;
        if (wr_i && hit_status) begin
            bank_d = wdata_i[CSOIR_BIT_BANK_HI:CSOIR_BIT_BANK_LO];
            // Flags only take the written value when no ALU update collides.
            if (!(alu_dest_status_i && alu_res.upd_zero)) begin
                zero_d = wdata_i[CSOIR_BIT_ZERO];
            end
            if (!(alu_dest_status_i && alu_res.upd_carry)) begin
                nib_d = wdata_i[CSOIR_BIT_NIBBLE];
                carry_d = wdata_i[CSOIR_BIT_CARRY];
            end
        end
        if (alu_res.upd_zero) begin
            zero_d = alu_res.zero;
        end
        if (alu_res.upd_carry) begin
            nib_d = alu_res.nibble;
        end
        if (alu_res.upd_carry || alu_i.op == CSOIR_OP_ROT_L || alu_i.op == CSOIR_OP_ROT_R) begin
            carry_d = alu_res.carry;
        end
        // Timeout and power-down bits ignore writes entirely.
        if (kick_watchdog_instr_i) begin
            wdt_n_d = 1'b1;
            sleep_n_d = 1'b1;
        end else if (sleep_instr_i) begin
            wdt_n_d = 1'b1;
            sleep_n_d = 1'b0;
        end
        if (wdt_timeout_i) begin
            wdt_n_d = 1'b0;
        end
        if (por_i) begin
            wdt_n_d = 1'b1;
            sleep_n_d = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Option and interrupt control next state
    // ------------------------------------------------------------------
    always_comb begin
        opt_d = opt_q;
        irq_d = irq_q;
        if (wr_i && hit_opt) begin
            opt_d = csoir_option_t'(wdata_i);
        end
        if (wr_i && hit_irq) begin
            irq_d = csoir_irq_t'(wdata_i);
        end
        // Events win over a clearing write in the same cycle.
        if (tick_ovf_evt_i) begin
            irq_d.tick_ovf_flag = 1'b1;
        end
        if (ext_pin_evt_i) begin
            irq_d.ext_pin_flag = 1'b1;
        end
        if (port_change_evt_i) begin
            irq_d.port_change_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Read data and request
    // ------------------------------------------------------------------
    // Reserved bit 7 of status reads zero; the upper bank bit is kept as written.
    always_comb begin
        rdata_d = 8'h00;
        if (hit_status) begin
            rdata_d = {1'b0, bank_d, wdt_n_d, sleep_n_d, zero_d, nib_d, carry_d};
        end else if (hit_irq) begin
            rdata_d = irq_d;
        end else if (hit_opt) begin
            rdata_d = opt_d;
        end
        irq_req_d = irq_d.global_irq_enable &&
            ((irq_d.tick_ovf_irq_enable && irq_d.tick_ovf_flag) ||
             (irq_d.ext_pin_irq_enable && irq_d.ext_pin_flag) ||
             (irq_d.port_change_irq_enable && irq_d.port_change_flag) ||
             (irq_d.periph_irq_enable && periph_pending_i));
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // The port-change flag is unknown at power-on; it resets to zero here.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bank_q <= CSOIR_BANK_RESET;
            wdt_n_q <= 1'b1;
            sleep_n_q <= 1'b1;
            zero_q <= 1'b0;
            nib_q <= 1'b0;
            carry_q <= 1'b0;
            opt_q <= CSOIR_OPTION_RESET;
            irq_q <= CSOIR_IRQ_RESET;
            rdata_q <= 8'h00;
            res_q <= 8'h00;
            tdiv_q <= 9'h001;
            wdiv_q <= 9'h0_80;
            irq_req_q <= 1'b0;
        end else begin
            bank_q <= bank_d;
            wdt_n_q <= wdt_n_d;
            sleep_n_q <= sleep_n_d;
            zero_q <= zero_d;
            nib_q <= nib_d;
            carry_q <= carry_d;
            opt_q <= opt_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
            res_q <= alu_res.result;
            tdiv_q <= tdiv;
            wdiv_q <= wdiv;
            irq_req_q <= irq_req_d;
        end
    end

    assign rdata_o = rdata_q;
    assign alu_result_o = res_q;
    assign bank_sel_o = bank_q;
    assign weak_pullup_off_o = opt_q.weak_pullup_off;
    assign ext_irq_edge_pol_o = opt_q.ext_irq_edge_pol;
    assign tick_source_sel_o = opt_q.tick_source_sel;
    assign tick_edge_sel_o = opt_q.tick_edge_sel;
    assign tick_div_o = tdiv_q;
    assign wdt_div_o = wdiv_q;
    assign periph_irq_enable_o = irq_q.periph_irq_enable;
    assign irq_req_o = irq_req_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_flag_sticky;
        @(posedge core_clk_i) disable iff (rst_i)
        (irq_q.tick_ovf_flag && !(wr_i && hit_irq)) |=> irq_q.tick_ovf_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_evt_sets;
        @(posedge core_clk_i) disable iff (rst_i)
        ext_pin_evt_i |=> irq_q.ext_pin_flag;
    endproperty
    a_evt_sets: assert property (p_evt_sets) else $error("event missed");

    property p_sleep_clears;
        @(posedge core_clk_i) disable iff (rst_i)
        (sleep_instr_i && !kick_watchdog_instr_i && !por_i) |=> !sleep_n_q;
    endproperty
    a_sleep_clears: assert property (p_sleep_clears) else $error("sleep flag");

    property p_wdt_clears;
        @(posedge core_clk_i) disable iff (rst_i)
        (wdt_timeout_i && !por_i) |=> !wdt_n_q;
    endproperty
    a_wdt_clears: assert property (p_wdt_clears) else $error("timeout flag");

    property p_no_write_to;
        @(posedge core_clk_i) disable iff (rst_i)
        (!kick_watchdog_instr_i && !sleep_instr_i && !wdt_timeout_i && !por_i)
            |=> $stable(wdt_n_q) && $stable(sleep_n_q);
    endproperty
    a_no_write_to: assert property (p_no_write_to) else $error("status written");

    property p_irq_req;
        @(posedge core_clk_i) disable iff (rst_i)
        (irq_q.global_irq_enable && irq_q.ext_pin_irq_enable && irq_q.ext_pin_flag) |-> irq_req_o;
    endproperty
    a_irq_req: assert property (p_irq_req) else $error("no request");

    property p_no_gie;
        @(posedge core_clk_i) disable iff (rst_i)
        !irq_q.global_irq_enable |-> !irq_req_o;
    endproperty
    a_no_gie: assert property (p_no_gie) else $error("request without enable");

    property p_opt_write;
        @(posedge core_clk_i) disable iff (rst_i)
        (wr_i && hit_opt) |=> (opt_q == $past(wdata_i));
    endproperty
    a_opt_write: assert property (p_opt_write) else $error("option write");

    property p_carry_add;
        @(posedge core_clk_i) disable iff (rst_i)
        (alu_i.op == CSOIR_OP_ADD) |=>
            carry_q == ((9'($past(alu_i.a)) + 9'($past(alu_i.b))) > 9'h0_ff);
    endproperty
    a_carry_add: assert property (p_carry_add) else $error("carry wrong");

endmodule

// ### verif/csoir_core_model.sv
/*
  Model of the instruction core that faces the register bank: one register
  access, one ALU operation and the event strobes per cycle.
  Assumes the bench calls cycle once per clock and nothing else drives
  the bank's request and event inputs.
*/
`timescale 1ns/1ps
module csoir_core_model
    import csoir_pkg::*;
(
    input wire logic core_clk_i,
    output logic por_o,
    output logic [8:0] addr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    output csoir_alu_req_t alu_o,
    output logic alu_dest_status_o,
    output logic kick_o,
    output logic sleep_o,
    output logic wdt_timeout_o,
    output logic tick_ovf_evt_o,
    output logic ext_pin_evt_o,
    output logic port_change_evt_o,
    output logic periph_pending_o
);
    // ------------------------------------------------------------------
    // Request driver
    // ------------------------------------------------------------------
    // Every signal is assigned once per call, so no strobe lingers.
    task automatic put(input logic [8:0] a, input logic w, input logic [7:0] d,
                       input csoir_alu_req_t r, input logic [8:0] ev);
        addr_o = a;
        wr_o = w;
        // Reserved bit 7 and upper bank bit 6 stay clear on every status write.
        wdata_o = (a[6:0] == 7'h03) ? (d & 8'h3f) : d;
        alu_o = r;
        periph_pending_o = ev[8];
        por_o = ev[7];
        alu_dest_status_o = ev[6];
        kick_o = ev[5];
        sleep_o = ev[4];
        wdt_timeout_o = ev[3];
        tick_ovf_evt_o = ev[2];
        ext_pin_evt_o = ev[1];
        port_change_evt_o = ev[0];
    endtask

    // Requests change only at the falling edge, clear of the sampling edge.
    task automatic cycle(input logic [8:0] a, input logic w, input logic [7:0] d,
                         input csoir_alu_req_t r, input logic [8:0] ev);
        @(negedge core_clk_i);
        put(a, w, d, r, ev);
    endtask

    // Idle with power-on raised from time zero.
    initial begin
        put(9'h000, 1'b0, 8'h00, '0, 9'h080);
    end
endmodule

// ### verif/csoir_regs_tb.sv
/*
  Self-checking bench for the status, option and interrupt-control bank.
  Assumes the core model drives all requests and every output settles one
  cycle after its cause, dividers two.
*/
`timescale 1ns/1ps
module csoir_regs_tb
    import csoir_pkg::*;
;
    localparam logic [8:0] EV_PEND = 9'h100;
    localparam logic [8:0] EV_DEST = 9'h040;
    localparam logic [8:0] EV_KICK = 9'h020;
    localparam logic [8:0] EV_SLEEP = 9'h010;
    localparam logic [8:0] EV_WDT = 9'h008;
    localparam logic [8:0] EV_TICK = 9'h004;
    localparam logic [8:0] EV_EXT = 9'h002;
    localparam logic [8:0] EV_PORT = 9'h001;
    typedef struct {int sel; logic [15:0] val; string nm;} csoir_exp_t;
    logic core_clk_i, rst_i, por_i, wr_i, alu_dest_status_i, kick_i, sleep_i, wdt_i;
    logic tick_i, ext_i, port_i, pend_i, wpo, eep, tss, tes, pie_o, irq_req_o;
    logic [8:0] addr_i, tick_div_o, wdt_div_o;
    logic [7:0] wdata_i, rdata_o, alu_result_o, d, irq;
    logic [1:0] bank_sel_o, bank;
    logic to_n, pd_n, z, dc, c, p;
    csoir_alu_req_t alu_i;
    csoir_exp_t exp_q[$];
    csoir_exp_t e;
    int err_total, n_checks;
    integer seed;

    csoir_core_model i_csoir_core_model (.core_clk_i(core_clk_i), .por_o(por_i),
        .addr_o(addr_i), .wr_o(wr_i), .wdata_o(wdata_i), .alu_o(alu_i),
        .alu_dest_status_o(alu_dest_status_i), .kick_o(kick_i), .sleep_o(sleep_i),
        .wdt_timeout_o(wdt_i), .tick_ovf_evt_o(tick_i), .ext_pin_evt_o(ext_i),
        .port_change_evt_o(port_i), .periph_pending_o(pend_i));
    csoir_regs i_csoir_regs (.core_clk_i(core_clk_i), .rst_i(rst_i), .por_i(por_i),
        .addr_i(addr_i), .wr_i(wr_i), .wdata_i(wdata_i), .alu_i(alu_i),
        .alu_dest_status_i(alu_dest_status_i), .kick_watchdog_instr_i(kick_i),
        .sleep_instr_i(sleep_i), .wdt_timeout_i(wdt_i), .tick_ovf_evt_i(tick_i),
        .ext_pin_evt_i(ext_i), .port_change_evt_i(port_i), .periph_pending_i(pend_i),
        .rdata_o(rdata_o), .alu_result_o(alu_result_o), .bank_sel_o(bank_sel_o),
        .weak_pullup_off_o(wpo), .ext_irq_edge_pol_o(eep), .tick_source_sel_o(tss),
        .tick_edge_sel_o(tes), .tick_div_o(tick_div_o), .wdt_div_o(wdt_div_o),
        .periph_irq_enable_o(pie_o), .irq_req_o(irq_req_o));

    // ------------------------------------------------------------------
    // Clock, comparison and verdict
    // ------------------------------------------------------------------
    // 200 MHz core clock.
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] ex);
        n_checks++;
        if (seen !== ex) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    task automatic conclude();
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Notes made at a falling edge are judged just after the next rising edge.
    always @(posedge core_clk_i) begin
        #1;
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            case (e.sel)
                0: check(e.nm, {8'h00, rdata_o}, e.val);
                1: check(e.nm, {8'h00, alu_result_o}, e.val);
                2: check(e.nm, {14'h0000, bank_sel_o}, e.val);
                3: check(e.nm, {12'h000, wpo, eep, tss, tes}, e.val);
                4: check(e.nm, {7'h00, tick_div_o}, e.val);
                5: check(e.nm, {7'h00, wdt_div_o}, e.val);
                6: check(e.nm, {15'h0000, irq_req_o}, e.val);
                default: check(e.nm, {15'h0000, pie_o}, e.val);
            endcase
        end
    end

    // Hang guard: the whole sequence needs far fewer cycles.
    initial begin
        repeat (5000) @(posedge core_clk_i);
        err_total++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------------
    task automatic note(input int sel, input logic [15:0] v, input string nm);
        exp_q.push_back('{sel, v, nm});
    endtask

    task automatic cyc(input logic [8:0] a, input logic w, input logic [7:0] dd,
                       input logic [8:0] ev);
        i_csoir_core_model.cycle(a, w, dd, '0, ev);
    endtask

    function automatic logic [15:0] st();
        return {8'h00, 1'b0, bank, to_n, pd_n, z, dc, c};
    endfunction

    // Runs one ALU operation while reading status in the same cycle.
    task automatic alu_case(input csoir_op_t o, input logic [7:0] a, input logic [7:0] b,
                            input logic [7:0] l, input logic w);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] res;
        bb = (o == CSOIR_OP_SUB) ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, o == CSOIR_OP_SUB};
        n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, o == CSOIR_OP_SUB};
        res = s[7:0];
        i_csoir_core_model.cycle(9'h003, w, 8'h00, '{o, a, b, l}, w ? EV_DEST : 9'h000);
        if (w) bank = 2'b00;
        case (o)
            CSOIR_OP_LOGIC: res = l;
            CSOIR_OP_ROT_L: begin res = {a[6:0], b[0]}; c = a[7]; end
            CSOIR_OP_ROT_R: begin res = {b[0], a[7:1]}; c = a[0]; end
            default: begin c = s[8]; dc = n[4]; end
        endcase
        if (o != CSOIR_OP_ROT_L && o != CSOIR_OP_ROT_R) z = (res == 8'h00);
        note(0, st(), "status flags");
        note(1, {8'h00, res}, "alu result");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        csoir_op_t t_op[10] = '{CSOIR_OP_ADD, CSOIR_OP_ADD, CSOIR_OP_SUB, CSOIR_OP_SUB,
            CSOIR_OP_SUB, CSOIR_OP_LOGIC, CSOIR_OP_LOGIC, CSOIR_OP_ROT_L, CSOIR_OP_ROT_R,
            CSOIR_OP_ROT_L};
        logic [7:0] t_a[10] = '{8'h0f, 8'hff, 8'h00, 8'h10, 8'h01, 0, 0, 8'h80, 8'h01, 8'h01};
        logic [7:0] t_b[10] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h02, 0, 0, 8'h00, 8'h01, 8'h00};
        err_total = 0;
        n_checks = 0;
        seed = 32'hc6ad;
        rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        for (int k = 0; k < 2; k++) begin
            bank = 2'b00; to_n = 1'b1; pd_n = 1'b1; z = 1'b0; dc = 1'b0; c = 1'b0;
            cyc(9'h081, 1'b0, 8'h00, 9'h000);
            note(0, 16'h00ff, "option reset");
            note(3, 16'h000f, "option outputs");
            note(4, 16'h0001, "timer divide reset");
            cyc(9'h003, 1'b0, 8'h00, 9'h000);
            note(0, st(), "status reset");
            note(2, 16'h0000, "bank select");
            cyc(9'h00b, 1'b0, 8'h00, 9'h000);
            note(0, 16'h0000, "irq reset");
            if (k == 0) begin
                // Disturb option, flags and timeout first, so the second reset has work.
                cyc(9'h081, 1'b1, 8'h00, EV_TICK | EV_WDT);
                cyc(9'h000, 1'b0, 8'h00, 9'h000);
                rst_i = 1'b1;
                @(negedge core_clk_i);
                rst_i = 1'b0;
            end
        end
        cyc(9'h001, 1'b0, 8'h00, 9'h000);
        note(0, 16'h0000, "unmapped");
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            cyc(9'h081, 1'b1, d, 9'h000);
            note(3, {12'h000, d[7:4]}, "option outputs");
            cyc(9'h081, 1'b0, 8'h00, 9'h000);
            note(0, {8'h00, d}, "option readback");
        end
        for (int k = 0; k < 16; k++) begin
            cyc(9'h081, 1'b1, {4'h5, 4'(k)}, 9'h000);
            repeat (2) cyc(9'h081, 1'b0, 8'h00, 9'h000);
            note(4, k[3] ? 16'h0001 : 16'h0002 << k[2:0], "timer divide");
            note(5, k[3] ? 16'h0001 << k[2:0] : 16'h0001, "watchdog divide");
        end
        cyc(9'h003, 1'b1, 8'h20, 9'h000);
        bank = 2'b01;
        note(2, 16'h0001, "bank select");
        cyc(9'h083, 1'b0, 8'h00, 9'h000);
        note(0, st(), "status mirror");
        cyc(9'h083, 1'b1, 8'h07, 9'h000);
        bank = 2'b00; z = 1'b1; dc = 1'b1; c = 1'b1;
        note(0, st(), "status write");
        cyc(9'h003, 1'b0, 8'h00, EV_WDT);
        to_n = 1'b0;
        note(0, st(), "watchdog expiry");
        cyc(9'h003, 1'b0, 8'h00, EV_SLEEP);
        to_n = 1'b1; pd_n = 1'b0;
        note(0, st(), "sleep");
        cyc(9'h003, 1'b0, 8'h00, EV_KICK);
        pd_n = 1'b1;
        note(0, st(), "kick");
        for (int i = 0; i < 10; i++) begin
            alu_case(t_op[i], t_a[i], t_b[i], (i == 6) ? 8'h5a : 8'h00, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            alu_case(i[0] ? CSOIR_OP_SUB : CSOIR_OP_ADD, 8'($random(seed)),
                     8'($random(seed)), 8'h00, 1'b0);
        end
        alu_case(CSOIR_OP_ADD, 8'hff, 8'h01, 8'h00, 1'b1);
        cyc(9'h00b, 1'b0, 8'h00, EV_TICK);
        note(0, 16'h0004, "irq flags");
        cyc(9'h08b, 1'b0, 8'h00, EV_EXT);
        note(0, 16'h0006, "irq flags");
        cyc(9'h00b, 1'b0, 8'h00, EV_PORT);
        note(0, 16'h0007, "irq flags");
        cyc(9'h00b, 1'b1, 8'h00, EV_TICK);
        note(0, 16'h0004, "irq clear race");
        cyc(9'h00b, 1'b0, 8'h00, 9'h000);
        note(0, 16'h0004, "irq hold");
        note(6, 16'h0000, "irq request");
        for (int i = 0; i < 8; i++) begin
            irq = (i == 0) ? 8'ha4 : (i == 1) ? 8'hc0 : 8'($random(seed));
            p = (i == 1) ? 1'b1 : 1'($random(seed));
            cyc(9'h00b, 1'b1, irq, p ? EV_PEND : 9'h000);
            cyc(9'h00b, 1'b0, 8'h00, p ? EV_PEND : 9'h000);
            note(0, {8'h00, irq}, "irq readback");
            note(7, {15'h0000, irq[6]}, "periph enable");
            note(6, {15'h0000, irq[7] & ((irq[5] & irq[2]) | (irq[4] & irq[1])
                 | (irq[3] & irq[0]) | (irq[6] & p))}, "irq request");
        end
        cyc(9'h000, 1'b0, 8'h00, 9'h000);
        @(posedge core_clk_i);
        #2;
        conclude();
    end
endmodule
